// ===== rtl/spd_defs.svh
`ifndef SPD_DEFS_SVH
`define SPD_DEFS_SVH
// Function
// - tx reset unloads buffers, zeroes count, self-clears
// - rx reset clears counts, errors, saved status
// - load bit latches addresses, holds until done
// - both loaded together, buffer A goes first
// - writing zero ignored; read shows busy
// - saved status 0, 2/3 once, 6/7 more
// - count saved only on first select rise
// - frame error flag per rx buffer
// - parity error flag per rx buffer
// - overrun flagged against buffer draining fifo
// - four active-buffer status bits
// - tx buffer spans start to inclusive end
// - rx buffer spans start to inclusive end
// - tx offset of next byte, zeroed
// - rx offset per buffer, zeroed on load
// - rx count write loads unloaded buffer
// - first error offset, zero when none
// - overrun offset is four bytes back
// - first error offset held until reload

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SPD_OFS_RX_BEG_A   16'hC800
`define SPD_OFS_RX_END_A   16'hC804
`define SPD_OFS_RX_BEG_B   16'hC808
`define SPD_OFS_RX_END_B   16'hC80C
`define SPD_OFS_TX_BEG_A   16'hC810
`define SPD_OFS_TX_END_A   16'hC814
`define SPD_OFS_TX_BEG_B   16'hC818
`define SPD_OFS_TX_END_B   16'hC81C
`define SPD_OFS_RX_CNT_A   16'hC820
`define SPD_OFS_RX_CNT_B   16'hC824
`define SPD_OFS_TX_CNT     16'hC828
`define SPD_OFS_STATUS     16'hC82C
`define SPD_OFS_CONTROL    16'hC830
`define SPD_OFS_RX_ERR_A   16'hC834
`define SPD_OFS_RX_ERR_B   16'hC838
`define SPD_OFS_RX_SAVED   16'hC870
`define SPD_ADDR_BLOCK     11'h640

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SPD_CTL_TX_RST     5
`define SPD_CTL_RX_RST     4
`define SPD_ADDR_RESET     32'h20000000
`define SPD_FIELD_RESET    13'h0000
`define SPD_OVF_BACK       13'h0004
`endif

// ===== rtl/spd_pkg.sv
package spd_pkg;
   typedef logic [12:0] spd_addr_t;
   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_WAIT = 2'b10} spd_tx_state_e;
   typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_WRITE = 2'b10} spd_rx_state_e;
endpackage

// ===== rtl/spd_dma.sv
`timescale 1ns/1ps
`default_nettype none
`include "spd_defs.svh"
module spd_dma #(
   parameter bit FIRST_CTRL = 1'b1
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                reset,
   // register bus
   input  wire logic [15:0]         address,
   input  wire logic                read,
   input  wire logic                write,
   input  wire logic [31:0]         writedata,
   input  wire logic [3:0]          byteenable,
   output logic      [31:0]         readdata,
   output logic                     waitrequest,
   // serial controller mode
   input  wire logic                uart_mode,
   input  wire logic                spi_slave_mode,
   input  wire logic                slave_select_low,
   // ram read port
   output logic                     mem_rd_req,
   output spd_pkg::spd_addr_t       mem_rd_addr,
   input  wire logic                mem_rd_valid,
   input  wire logic [7:0]          mem_rd_data,
   // transmit fifo
   input  wire logic                tx_fifo_space,
   output logic                     tx_push,
   output logic      [7:0]          tx_push_data,
   // receive fifo
   input  wire logic                rx_fifo_valid,
   input  wire logic [7:0]          rx_fifo_data,
   input  wire logic                rx_fifo_frame_err,
   input  wire logic                rx_fifo_parity_err,
   input  wire logic                rx_fifo_overrun,
   output logic                     rx_fifo_pop,
   // ram write port
   output logic                     mem_wr_req,
   output spd_pkg::spd_addr_t       mem_wr_addr,
   output logic      [7:0]          mem_wr_data,
   input  wire logic                mem_wr_ack
);

   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic spd_pkg::spd_addr_t merge13(input spd_pkg::spd_addr_t old,
                                                  input logic [31:0] wd,
                                                  input logic [3:0] be);
      merge13 = {be[1] ? wd[12:8] : old[12:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
      hit = (a == o);
   endfunction

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic                      ack_r;
   logic [31:0]               rdata_r;
   logic [31:0]               rd_val;
   wire logic                 wr_fire   = write & ack_r;
   wire logic                 addr_blk  = (address[15:5] == `SPD_ADDR_BLOCK) &&
                                          (address[1:0] == 2'h0);
   wire logic                 ctl_wr    = wr_fire & hit(address, `SPD_OFS_CONTROL) &
                                          byteenable[0];
   wire logic                 tx_rst    = ctl_wr & writedata[`SPD_CTL_TX_RST];
   wire logic                 rx_rst    = ctl_wr & writedata[`SPD_CTL_RX_RST];
   wire logic [1:0]           cnt_wr    = {wr_fire & hit(address, `SPD_OFS_RX_CNT_B),
                                           wr_fire & hit(address, `SPD_OFS_RX_CNT_A)};

   assign waitrequest = (read | write) & ~ack_r;
   assign readdata    = rdata_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h00000000;
      end else begin
         ack_r <= (read | write) & ~ack_r;
         if (read & ~ack_r)
            rdata_r <= rd_val;
      end
   end

   // ----------------------------------------
   // address registers and shadows
   // ----------------------------------------
   spd_pkg::spd_addr_t        addr_r [8];
   spd_pkg::spd_addr_t        sh_beg_r [4];
   spd_pkg::spd_addr_t        sh_end_r [4];
   logic [1:0]                tx_ld_r;
   logic [1:0]                rx_ld_r;
   wire logic [1:0]           tx_set = ctl_wr ? writedata[3:2] : 2'b00;
   wire logic [1:0]           rx_set = (ctl_wr ? writedata[1:0] : 2'b00) | (cnt_wr & ~rx_ld_r);
   wire logic [3:0]           ld_set = {tx_set, rx_set};

   genvar g;
   for (g = 0; g < 8; g++) begin : g_addr
      always_ff @(posedge clk or posedge reset) begin
         if (reset)
            addr_r[g] <= `SPD_FIELD_RESET;
         else if (wr_fire && addr_blk && address[4:2] == 3'(g))
            addr_r[g] <= merge13(addr_r[g], writedata, byteenable);
      end
   end

   // buffer index: 0 rx a, 1 rx b, 2 tx a, 3 tx b
   for (g = 0; g < 4; g++) begin : g_shadow
      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            sh_beg_r[g] <= `SPD_FIELD_RESET;
            sh_end_r[g] <= `SPD_FIELD_RESET;
         end else if (ld_set[g]) begin
            sh_beg_r[g] <= addr_r[2*g];
            sh_end_r[g] <= addr_r[2*g+1];
         end
      end
   end

   // ----------------------------------------
   // transmit channel
   // ----------------------------------------
   spd_pkg::spd_tx_state_e    tx_st_r;
   logic                      tx_cur_r;
   spd_pkg::spd_addr_t        tx_cnt_r;
   spd_pkg::spd_addr_t        rd_addr_r;
   logic                      tx_push_r;
   logic [7:0]                tx_data_r;
   wire logic                 tx_sel   = tx_ld_r[tx_cur_r] ? tx_cur_r : ~tx_ld_r[0];
   wire logic                 tx_start = (tx_st_r == spd_pkg::TX_IDLE) & tx_ld_r[tx_sel] &
                                         tx_fifo_space & ~tx_push_r & ~tx_rst;
   wire logic                 tx_got   = (tx_st_r == spd_pkg::TX_WAIT) & mem_rd_valid;
   wire logic                 tx_last  = rd_addr_r == sh_end_r[{1'b1, tx_cur_r}];
   wire logic [1:0]           tx_done  = (tx_got & tx_last) ? (tx_cur_r ? 2'b10 : 2'b01) : 2'b00;

   assign mem_rd_req   = tx_st_r == spd_pkg::TX_WAIT;
   assign mem_rd_addr  = rd_addr_r;
   assign tx_push      = tx_push_r;
   assign tx_push_data = tx_data_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_st_r   <= spd_pkg::TX_IDLE;
         tx_cur_r  <= 1'b0;
         tx_ld_r   <= 2'b00;
         tx_cnt_r  <= `SPD_FIELD_RESET;
         rd_addr_r <= `SPD_FIELD_RESET;
         tx_push_r <= 1'b0;
         tx_data_r <= 8'h00;
      end else begin
         tx_push_r <= tx_got & ~tx_rst;
         if (tx_got)
            tx_data_r <= mem_rd_data;
         if (tx_rst) begin
            tx_st_r  <= spd_pkg::TX_IDLE;
            tx_ld_r  <= 2'b00;
            tx_cnt_r <= `SPD_FIELD_RESET;
         end else begin
            tx_ld_r <= (tx_ld_r & ~tx_done) | tx_set;
            if (tx_set != 2'b00 && tx_ld_r == 2'b00) begin
               tx_cnt_r <= `SPD_FIELD_RESET;
               tx_cur_r <= 1'b0;
            end
            case (tx_st_r)
               spd_pkg::TX_IDLE: begin
                  if (tx_start) begin
                     tx_st_r   <= spd_pkg::TX_WAIT;
                     tx_cur_r  <= tx_sel;
                     rd_addr_r <= sh_beg_r[{1'b1, tx_sel}] + tx_cnt_r;
                  end
               end
               spd_pkg::TX_WAIT: begin
                  if (tx_got) begin
                     tx_st_r  <= spd_pkg::TX_IDLE;
                     tx_cnt_r <= tx_last ? `SPD_FIELD_RESET : tx_cnt_r + 13'h0001;
                  end
               end
               default: tx_st_r <= spd_pkg::TX_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // receive channel
   // ----------------------------------------
   spd_pkg::spd_rx_state_e    rx_st_r;
   logic                      rx_cur_r;
   spd_pkg::spd_addr_t        wr_addr_r;
   logic [7:0]                wr_data_r;
   spd_pkg::spd_addr_t        rx_cnt_r [2];
   spd_pkg::spd_addr_t        rx_err_r [2];
   logic [1:0]                seen_r;
   logic [1:0]                frm_r;
   logic [1:0]                par_r;
   logic [1:0]                ovr_r;
   wire logic                 rx_sel   = rx_ld_r[rx_cur_r] ? rx_cur_r : ~rx_ld_r[0];
   wire logic                 e_frm    = FIRST_CTRL & uart_mode & rx_fifo_frame_err;
   wire logic                 e_par    = FIRST_CTRL & uart_mode & rx_fifo_parity_err;
   wire logic                 e_any    = e_frm | e_par | rx_fifo_overrun;
   wire logic                 rx_wdone = (rx_st_r == spd_pkg::RX_WRITE) & mem_wr_ack;
   wire logic                 rx_last  = wr_addr_r == sh_end_r[{1'b0, rx_cur_r}];
   wire logic [1:0]           rx_done  = (rx_wdone & rx_last) ? (rx_cur_r ? 2'b10 : 2'b01)
                                         : 2'b00;
   wire logic [1:0]           rx_clr   = rx_set | {rx_rst, rx_rst};

   assign rx_fifo_pop = (rx_st_r == spd_pkg::RX_IDLE) & rx_ld_r[rx_sel] & rx_fifo_valid &
                        ~rx_rst;
   assign mem_wr_req  = rx_st_r == spd_pkg::RX_WRITE;
   assign mem_wr_addr = wr_addr_r;
   assign mem_wr_data = wr_data_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_st_r   <= spd_pkg::RX_IDLE;
         rx_cur_r  <= 1'b0;
         rx_ld_r   <= 2'b00;
         wr_addr_r <= `SPD_FIELD_RESET;
         wr_data_r <= 8'h00;
      end else if (rx_rst) begin
         rx_st_r <= spd_pkg::RX_IDLE;
         rx_ld_r <= 2'b00;
      end else begin
         rx_ld_r <= (rx_ld_r & ~rx_done) | rx_set;
         if (rx_set != 2'b00 && rx_ld_r == 2'b00)
            rx_cur_r <= 1'b0;
         case (rx_st_r)
            spd_pkg::RX_IDLE: begin
               if (rx_fifo_pop) begin
                  rx_st_r   <= spd_pkg::RX_WRITE;
                  rx_cur_r  <= rx_sel;
                  wr_addr_r <= sh_beg_r[{1'b0, rx_sel}] + rx_cnt_r[rx_sel];
                  wr_data_r <= rx_fifo_data;
               end
            end
            spd_pkg::RX_WRITE: begin
               if (rx_wdone)
                  rx_st_r <= spd_pkg::RX_IDLE;
            end
            default: rx_st_r <= spd_pkg::RX_IDLE;
         endcase
      end
   end

   for (g = 0; g < 2; g++) begin : g_rxbuf
      wire logic              take  = rx_fifo_pop & (rx_sel == 1'(g));
      wire logic              wdone = rx_wdone & (rx_cur_r == 1'(g));
      wire spd_pkg::spd_addr_t e_off = rx_fifo_overrun ? rx_cnt_r[g] - `SPD_OVF_BACK
                                                       : rx_cnt_r[g];
      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            rx_cnt_r[g] <= `SPD_FIELD_RESET;
            rx_err_r[g] <= `SPD_FIELD_RESET;
            seen_r[g]   <= 1'b0;
            frm_r[g]    <= 1'b0;
            par_r[g]    <= 1'b0;
            ovr_r[g]    <= 1'b0;
         end else begin
            if (rx_rst)
               rx_cnt_r[g] <= `SPD_FIELD_RESET;
            else if (cnt_wr[g])
               rx_cnt_r[g] <= merge13(rx_cnt_r[g], writedata, byteenable);
            else if (rx_set[g])
               rx_cnt_r[g] <= `SPD_FIELD_RESET;
            else if (wdone)
               rx_cnt_r[g] <= rx_cnt_r[g] + 13'h0001;
            frm_r[g]  <= (frm_r[g] & ~rx_clr[g]) | (take & e_frm);
            par_r[g]  <= (par_r[g] & ~rx_clr[g]) | (take & e_par);
            ovr_r[g]  <= (ovr_r[g] & ~rx_clr[g]) | (take & rx_fifo_overrun);
            seen_r[g] <= (seen_r[g] & ~rx_clr[g]) | (take & e_any);
            if (take && e_any && (!seen_r[g] || rx_clr[g]))
               rx_err_r[g] <= e_off;
            else if (rx_clr[g])
               rx_err_r[g] <= `SPD_FIELD_RESET;
         end
      end
   end

   // ----------------------------------------
   // slave select capture
   // ----------------------------------------
   logic                      ss1_r;
   logic                      ss2_r;
   logic                      ss3_r;
   logic                      ss_st_r;
   logic [2:0]                sel_st_r;
   spd_pkg::spd_addr_t        saved_r;
   wire logic                 ss_rise = (ss2_r == ss3_r) & ss3_r & ~ss_st_r;
   wire logic                 sel_clr = rx_rst | (rx_set != 2'b00);
   wire logic [2:0]           sel_base = sel_clr ? 3'h0 : sel_st_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ss1_r    <= 1'b1;
         ss2_r    <= 1'b1;
         ss3_r    <= 1'b1;
         ss_st_r  <= 1'b1;
         sel_st_r <= 3'h0;
         saved_r  <= `SPD_FIELD_RESET;
      end else begin
         ss1_r <= slave_select_low;
         ss2_r <= ss1_r;
         ss3_r <= ss2_r;
         if (ss2_r == ss3_r)
            ss_st_r <= ss3_r;
         if (rx_rst)
            saved_r <= `SPD_FIELD_RESET;
         if (ss_rise && spi_slave_mode && !rx_rst) begin
            if (sel_base == 3'h0) begin
               saved_r  <= rx_cnt_r[rx_cur_r];
               sel_st_r <= {2'b01, rx_cur_r};
            end else begin
               sel_st_r <= sel_base | 3'h4;
            end
         end else begin
            sel_st_r <= sel_base;
         end
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   wire logic [3:0]           act = {tx_ld_r[1] & tx_cur_r, tx_ld_r[0] & ~tx_cur_r,
                                     rx_ld_r[1] & rx_cur_r, rx_ld_r[0] & ~rx_cur_r};

   always_comb begin
      rd_val = 32'h00000000;
      if (addr_blk)
         rd_val = `SPD_ADDR_RESET | {19'h00000, addr_r[address[4:2]]};
      else case (address)
         `SPD_OFS_RX_CNT_A: rd_val = {19'h00000, rx_cnt_r[0]};
         `SPD_OFS_RX_CNT_B: rd_val = {19'h00000, rx_cnt_r[1]};
         `SPD_OFS_TX_CNT:   rd_val = {19'h00000, tx_cnt_r};
         `SPD_OFS_STATUS:   rd_val = {19'h00000, sel_st_r, frm_r, par_r, ovr_r, act};
         `SPD_OFS_CONTROL:  rd_val = {28'h0000000, tx_ld_r, rx_ld_r};
         `SPD_OFS_RX_ERR_A: rd_val = {19'h00000, rx_err_r[0]};
         `SPD_OFS_RX_ERR_B: rd_val = {19'h00000, rx_err_r[1]};
         `SPD_OFS_RX_SAVED: rd_val = {19'h00000, saved_r};
         default:           rd_val = 32'h00000000;
      endcase
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   wire logic                 take_a_frm = g_rxbuf[0].take & e_frm & ~rx_clr[0];
   wire spd_pkg::spd_addr_t   rx_next    = sh_beg_r[{1'b0, rx_sel}] + rx_cnt_r[rx_sel];

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_tx_rst_clears: assert property (tx_rst |=> tx_ld_r == 2'b00 && tx_cnt_r == 13'h0000)
      else $error("tx reset did not clear channel");
   a_rx_rst_clears: assert property (rx_rst |=> rx_ld_r == 2'b00 && sel_st_r == 3'h0 &&
                                     rx_err_r[0] == 13'h0000 && frm_r == 2'b00)
      else $error("rx reset did not clear channel");
   a_load_sets: assert property (ctl_wr && writedata[2] && !tx_rst |=> tx_ld_r[0])
      else $error("tx load a not set");
   a_a_first: assert property (tx_ld_r == 2'b00 ##1 tx_ld_r == 2'b11 |-> !tx_sel)
      else $error("buffer b chosen before a");
   a_load_holds: assert property (tx_ld_r[0] && !tx_done[0] && !tx_rst |=> tx_ld_r[0])
      else $error("load bit dropped early");
   a_sel_legal: assert property (sel_st_r != 3'h1 && sel_st_r != 3'h4 &&
                                 sel_st_r != 3'h5)
      else $error("reserved saved status");
   a_saved_once: assert property (sel_st_r != 3'h0 && !sel_clr |=> $stable(saved_r))
      else $error("saved count overwritten");
   a_frame_set: assert property (take_a_frm |=> frm_r[0])
      else $error("frame flag a not set");
   a_parity_set: assert property (g_rxbuf[1].take && e_par && !rx_clr[1] |=> par_r[1])
      else $error("parity flag b not set");
   a_ovr_offset: assert property (g_rxbuf[1].take && rx_fifo_overrun && !seen_r[1]
                                  |=> rx_err_r[1] == $past(rx_cnt_r[1]) - 13'h0004)
      else $error("overrun offset wrong");
   a_err_hold: assert property (seen_r[1] && !rx_clr[1] |=> $stable(rx_err_r[1]))
      else $error("first error offset changed");
   a_rx_addr: assert property (rx_fifo_pop |=> mem_wr_req && mem_wr_addr ==
                               $past(rx_next))
      else $error("rx write address wrong");

   c_tx_both: cover property (tx_ld_r == 2'b11 ##[1:50] tx_done[0]);
   c_tx_switch: cover property (tx_done[0] ##[1:50] tx_done[1]);
   c_rx_err: cover property (seen_r[0] && ovr_r[0]);
   c_ss_twice: cover property (sel_st_r[2]);

endmodule
`default_nettype wire

// ===== test/spd_far.sv
`timescale 1ns/1ps
`default_nettype none
module spd_far (
   // clock and knobs
   input  wire logic        clk,
   input  wire logic        rd_slow,
   input  wire logic        tx_full,
   // ram ports
   input  wire logic        mem_rd_req,
   input  wire logic [12:0] mem_rd_addr,
   output logic             mem_rd_valid,
   output logic [7:0]       mem_rd_data,
   input  wire logic        mem_wr_req,
   input  wire logic [12:0] mem_wr_addr,
   input  wire logic [7:0]  mem_wr_data,
   output logic             mem_wr_ack,
   // fifos
   output logic             tx_fifo_space,
   input  wire logic        tx_push,
   input  wire logic [7:0]  tx_push_data,
   output logic             rx_fifo_valid,
   output logic [7:0]       rx_fifo_data,
   output logic             rx_fifo_frame_err,
   output logic             rx_fifo_parity_err,
   output logic             rx_fifo_overrun,
   input  wire logic        rx_fifo_pop
);
   logic [7:0]  ram [8192];
   logic [7:0]  txq [$];
   logic [10:0] rxq [$];
   logic [7:0]  last_r = 8'h00;
   logic        wait_r = 1'b0;
   initial begin
      for (int i = 0; i < 8192; i++) ram[i] = 8'(i) ^ 8'h5A;
      {rx_fifo_valid, rx_fifo_overrun, rx_fifo_parity_err, rx_fifo_frame_err} = 4'h0;
      rx_fifo_data = 8'h00;
   end
   // slow mode answers every other cycle; idle data is the inverse
   assign mem_rd_valid  = mem_rd_req & (~rd_slow | wait_r);
   assign mem_rd_data   = mem_rd_valid ? ram[mem_rd_addr] : ~last_r;
   assign mem_wr_ack    = mem_wr_req;
   assign tx_fifo_space = ~tx_full;
   always @(posedge clk) begin
      wait_r <= mem_rd_req & ~mem_rd_valid;
      if (mem_rd_valid) last_r <= mem_rd_data;
      if (mem_wr_req) ram[mem_wr_addr] <= mem_wr_data;
      if (tx_push) txq.push_back(tx_push_data);
      if (rx_fifo_pop) void'(rxq.pop_front());
      rx_fifo_valid <= rxq.size() > 0;
      if (rxq.size() > 0)
         {rx_fifo_overrun, rx_fifo_parity_err, rx_fifo_frame_err, rx_fifo_data} <= rxq[0];
      else
         rx_fifo_data <= ~rx_fifo_data;
   end
endmodule
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "spd_defs.svh"
module tb;
   logic clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
   logic [15:0] address = 16'h0000;
   logic [31:0] writedata = 32'h0, readdata, rdv;
   logic [3:0]  byteenable = 4'hF;
   logic waitrequest, uart_mode = 1'b1, spi_slave_mode = 1'b0, slave_select_low = 1'b1;
   logic rd_slow = 1'b0, tx_full = 1'b1, mem_rd_req, mem_rd_valid, tx_fifo_space, tx_push;
   logic rx_fifo_valid, rx_fifo_frame_err, rx_fifo_parity_err, rx_fifo_overrun, rx_fifo_pop;
   logic mem_wr_req, mem_wr_ack;
   logic [7:0]  mem_rd_data, tx_push_data, rx_fifo_data, mem_wr_data;
   spd_pkg::spd_addr_t mem_rd_addr, mem_wr_addr;
   int n_errors = 0, checked = 0;

   spd_dma DUT (.clk, .reset, .address, .read, .write, .writedata, .byteenable, .readdata,
      .waitrequest, .uart_mode, .spi_slave_mode, .slave_select_low, .mem_rd_req,
      .mem_rd_addr, .mem_rd_valid, .mem_rd_data, .tx_fifo_space, .tx_push, .tx_push_data,
      .rx_fifo_valid, .rx_fifo_data, .rx_fifo_frame_err, .rx_fifo_parity_err,
      .rx_fifo_overrun, .rx_fifo_pop, .mem_wr_req, .mem_wr_addr, .mem_wr_data, .mem_wr_ack);
   spd_far far (.clk, .rd_slow, .tx_full, .mem_rd_req, .mem_rd_addr, .mem_rd_valid,
      .mem_rd_data, .mem_wr_req, .mem_wr_addr, .mem_wr_data, .mem_wr_ack, .tx_fifo_space,
      .tx_push, .tx_push_data, .rx_fifo_valid, .rx_fifo_data, .rx_fifo_frame_err,
      .rx_fifo_parity_err, .rx_fifo_overrun, .rx_fifo_pop);

   always #2.5 clk = ~clk;

   // ------------------------------------
   // bus and check tasks
   // ------------------------------------
   task automatic fail(input string s);
      n_errors++;
      $display("[ERR] %0t %s", $time, s);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) fail($sformatf("got %h exp %h", got, exp));
   endtask
   task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) fail("bus hang");
      rdv = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdv, e);
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic rx_drain;
      for (int i = 0; i < 200 && far.rxq.size() > 0; i++) @(posedge clk);
      idle(4);
   endtask
   task automatic sel_rise;
      slave_select_low <= 1'b0;
      idle(6);
      slave_select_low <= 1'b1;
      idle(8);
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fail("watchdog");
      print_verdict();
   end

   // ------------------------------------
   // tests
   // ------------------------------------
   initial begin
      idle(6);
      reset <= 1'b0;
      rd(`SPD_OFS_RX_BEG_A, 32'h20000000);
      rd(`SPD_OFS_CONTROL, 32'h0);
      rd(`SPD_OFS_RX_ERR_A, 32'h0);
      bus(1'b1, 16'hC840, 32'h1FFF);
      rd(16'hC840, 32'h0);
      $display("test reset done");
      // both tx buffers in one write, B is a single byte
      bus(1'b1, `SPD_OFS_TX_BEG_A, 32'h10);
      bus(1'b1, `SPD_OFS_TX_END_A, 32'h12);
      bus(1'b1, `SPD_OFS_TX_BEG_B, 32'h20);
      bus(1'b1, `SPD_OFS_TX_END_B, 32'h20);
      bus(1'b1, `SPD_OFS_CONTROL, 32'h0C);
      rd(`SPD_OFS_CONTROL, 32'h0C);
      bus(1'b1, `SPD_OFS_CONTROL, 32'h00);
      rd(`SPD_OFS_CONTROL, 32'h0C);
      rd(`SPD_OFS_STATUS, 32'h4);
      rd(`SPD_OFS_TX_CNT, 32'h0);
      tx_full <= 1'b0;
      rd_slow <= 1'b1;
      for (int i = 0; i < 300 && far.txq.size() < 4; i++) @(posedge clk);
      idle(10);
      chk(far.txq.size(), 4);
      foreach (far.txq[i])
         chk(far.txq[i], 32'((i < 3 ? 8'h10 + 8'(i) : 8'h20) ^ 8'h5A));
      rd(`SPD_OFS_CONTROL, 32'h0);
      rd(`SPD_OFS_TX_CNT, 32'h0);
      $display("test tx done");
      // rx bytes wait in the fifo until buffers are loaded
      bus(1'b1, `SPD_OFS_RX_BEG_A, 32'h100);
      bus(1'b1, `SPD_OFS_RX_END_A, 32'h101);
      bus(1'b1, `SPD_OFS_RX_BEG_B, 32'h200);
      bus(1'b1, `SPD_OFS_RX_END_B, 32'h202);
      far.rxq = '{11'h0A0, 11'h1A1, 11'h0B0, 11'h4B1, 11'h2B2};
      bus(1'b1, `SPD_OFS_CONTROL, 32'h01);
      rx_drain();
      chk(far.rxq.size(), 3);
      rd(`SPD_OFS_RX_CNT_A, 32'h2);
      bus(1'b1, `SPD_OFS_RX_CNT_B, 32'h0);
      rx_drain();
      chk(far.ram[13'h101], 32'hA1);
      chk(far.ram[13'h202], 32'hB2);
      rd(`SPD_OFS_STATUS, 32'h1A0);
      rd(`SPD_OFS_RX_ERR_A, 32'h1);
      rd(`SPD_OFS_RX_ERR_B, 32'h1FFD);
      rd(`SPD_OFS_RX_CNT_B, 32'h3);
      bus(1'b1, `SPD_OFS_CONTROL, 32'h10);
      rd(`SPD_OFS_STATUS, 32'h0);
      rd(`SPD_OFS_RX_ERR_B, 32'h0);
      rd(`SPD_OFS_RX_CNT_B, 32'h0);
      $display("test rx done");
      // saved count only on the first select rise
      spi_slave_mode <= 1'b1;
      uart_mode <= 1'b0;
      bus(1'b1, `SPD_OFS_CONTROL, 32'h01);
      far.rxq.push_back(11'h1C0);
      rx_drain();
      sel_rise();
      rd(`SPD_OFS_RX_SAVED, 32'h1);
      rd(`SPD_OFS_STATUS, 32'h801);
      far.rxq.push_back(11'h0C1);
      rx_drain();
      sel_rise();
      rd(`SPD_OFS_RX_SAVED, 32'h1);
      rd(`SPD_OFS_STATUS, 32'h1800);
      $display("test saved done");
      // tx reset while a buffer waits on a full fifo
      tx_full <= 1'b1;
      bus(1'b1, `SPD_OFS_TX_BEG_A, 32'h30);
      bus(1'b1, `SPD_OFS_TX_END_A, 32'h3F);
      bus(1'b1, `SPD_OFS_CONTROL, 32'h04);
      rd(`SPD_OFS_CONTROL, 32'h04);
      bus(1'b1, `SPD_OFS_CONTROL, 32'h20);
      rd(`SPD_OFS_CONTROL, 32'h0);
      rd(`SPD_OFS_TX_CNT, 32'h0);
      tx_full <= 1'b0;
      idle(20);
      chk(far.txq.size(), 4);
      $display("test tx reset done");
      print_verdict();
   end
endmodule
`default_nettype wire
